// ---- rtl/hdrc_map.svh ----
// address map, field positions and reset values of the host decoder
// assumes the includer supplies timescale and nettype settings
`ifndef HDRC_MAP_SVH
`define HDRC_MAP_SVH

// bits 31:26 of the address implied by each host chip-select region
`define HDRC_HI_BOOT 6'h07
`define HDRC_HI_WAIT0 6'h1b
`define HDRC_HI_WAIT1 6'h1c
`define HDRC_HI_REG 6'h04

// positions of full address bits inside the latched upper address
`define HDRC_A25 12
`define HDRC_A24 11
`define HDRC_A23 10
`define HDRC_A22 9
`define HDRC_A13 0

// boot region, rom and debug eprom windows
`define HDRC_ROM_BASE 32'h1c000000
`define HDRC_ROM_SIZE 32'h04000000
`define HDRC_EPROM_BASE 32'h1fc00000
`define HDRC_EPROM_SIZE 32'h00200000

// wait-capable region 0 and 1 windows
`define HDRC_VRAM_BASE 32'h6c000000
`define HDRC_VRAM_SIZE 32'h00400000
`define HDRC_PAL_LCD_BASE 32'h6c400000
`define HDRC_PAL_CRT_BASE 32'h6c401000
`define HDRC_BLIT_BASE 32'h6c402000
`define HDRC_USB_BASE 32'h6c403000
`define HDRC_FLASH_BASE 32'h6c418000
`define HDRC_DEBUG_BASE 32'h6c419000
`define HDRC_IOBUS_BASE 32'h6c410000
`define HDRC_IOBUS_SIZE 32'h00006000
`define HDRC_PCIO0_BASE 32'h6c600000
`define HDRC_PCIO1_BASE 32'h6c700000
`define HDRC_PCIO_SIZE 32'h00100000
`define HDRC_PCMEM0_BASE 32'h6c800000
`define HDRC_PCMEM0_SIZE 32'h03800000
`define HDRC_PCMEM1_BASE 32'h70000000
`define HDRC_PCMEM1_SIZE 32'h04000000

// no-wait register windows
`define HDRC_RBUS_BASE 32'h10800000
`define HDRC_RDISP_BASE 32'h10801000
`define HDRC_RPCC_BASE 32'h10805000
`define HDRC_RIOB_BASE 32'h10806000
`define HDRC_RPWR_BASE 32'h10807000
`define HDRC_RINT_BASE 32'h10808000
`define HDRC_WIN4K 32'h00001000

// rom control register inside the power window
`define HDRC_ROM_CTRL_OFS 32'h00000008
`define HDRC_SZ_MSB 1
`define HDRC_SZ_LSB 0
`define HDRC_SZ_8MB 2'h0
`define HDRC_SZ_4MB 2'h1
`define HDRC_SZ_16MB 2'h2
`define HDRC_SZ_RST 2'h0

`endif

// ---- rtl/hdrc_pkg.sv ----
// types shared by the host decoder and its surroundings
// assumes the address map header is included where numbers are needed
package hdrc_pkg;

  typedef enum logic [1:0] {
    HDRC_IDLE = 2'b00,
    HDRC_ACTIVE = 2'b01,
    HDRC_HELD = 2'b10
  } hdrc_state_e;

  // one select per internal unit, active high
  typedef struct packed {
    logic vram;
    logic pal_lcd;
    logic pal_crt;
    logic blit;
    logic usb;
    logic flash;
    logic debug;
    logic iobus;
    logic pc_io;
    logic pc_mem;
    logic reg_bus;
    logic reg_disp;
    logic reg_pccard;
    logic reg_iobus;
    logic reg_power;
    logic reg_intr;
  } hdrc_unit_sel_s;

endpackage

// ---- rtl/hdrc_top.sv ----
// host address decoder, unit selects, wait generation and rom control
// assumes every host pin is timed by ref_clk, which is the host bus clock
`timescale 1ns/1ps
`default_nettype none
`include "hdrc_map.svh"

// Behaviour
// - rom reached only through boot region
// - wait regions carry vram, card, iobus, flash
// - register region decoded, never waited
// - vram and both palette windows decoded
// - blit, usb, flash, debug windows decoded
// - iobus window and pc card io windows
// - wait region 1 all pc card memory
// - six no-wait register windows decoded
// - drive rom address bits 22 to 13
// - two-bit bank size field selects mapping
// - size field resets to 8 MB code
// - 4 MB and 8 MB bank layouts
// - 16 MB: bank 0 carries address 23
// - debug eprom 2 MB window at 1fc00000
// - all timing from host bus clock
// - strobe latches upper address for rom
// - one active-low shared wait output
module hdrc_top (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [12:0] host_addr,
  input wire logic upper_addr_latch_strobe,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic [3:0] host_byte_en_n,
  input wire logic [31:0] host_wdata,
  input wire logic boot_region_select_n,
  input wire logic wait_region_0_select_n,
  input wire logic wait_region_1_select_n,
  input wire logic register_region_select_n,
  input wire logic eprom_debug_mode,
  input wire logic [31:0] unit_rdata,
  input wire logic unit_done,
  output logic [31:0] host_rdata,
  output logic host_rdata_oe_n,
  output logic host_wait_out_n,
  output hdrc_pkg::hdrc_unit_sel_s unit_sel,
  output logic [9:0] rom_upper_addr,
  output logic [7:0] rom_bank_select_pins,
  output logic rom_oe_n,
  output logic [1:0] rom_bank_size_sel
);

  function automatic logic in_win(input logic [31:0] a,
                                  input logic [31:0] base,
                                  input logic [31:0] size);
    in_win = (a >= base) && (a < base + size);
  endfunction

  hdrc_pkg::hdrc_state_e state_q;
  hdrc_pkg::hdrc_unit_sel_s hit;
  hdrc_pkg::hdrc_unit_sel_s sel_q;
  logic [12:0] upper_q;
  logic [1:0] size_q;
  logic [31:0] full_addr;
  logic [5:0] region_hi;
  logic any_cs;
  logic strobe;
  logic start;
  logic rom_hit;
  logic ctrl_hit;
  logic need_wait;
  logic [7:0] bank_n;
  logic wait_q;
  logic ctrl_q;
  logic rom_q;
  logic rd_q;
  logic [31:0] rdata_q;
  logic rdata_oe_n_q;
  logic [7:0] bank_q;
  logic rom_oe_n_q;

  assign strobe = !host_rd_n || !host_wr_n;

  // chip-select priority only matters if the host misprograms overlaps
  always_comb begin
    any_cs = 1'b1;
    region_hi = `HDRC_HI_REG;
    if (!boot_region_select_n) begin
      region_hi = `HDRC_HI_BOOT;
    end else if (!wait_region_0_select_n) begin
      region_hi = `HDRC_HI_WAIT0;
    end else if (!wait_region_1_select_n) begin
      region_hi = `HDRC_HI_WAIT1;
    end else if (!register_region_select_n) begin
      region_hi = `HDRC_HI_REG;
    end else begin
      any_cs = 1'b0;
    end
    full_addr = {region_hi, upper_q, host_addr};
  end

  always_comb begin
    hit = '0;
    rom_hit = 1'b0;
    ctrl_hit = 1'b0;
    need_wait = 1'b0;
    if (!boot_region_select_n) begin
      rom_hit = in_win(full_addr, `HDRC_ROM_BASE, `HDRC_ROM_SIZE) &&
                (!eprom_debug_mode ||
                 in_win(full_addr, `HDRC_EPROM_BASE,
                        `HDRC_EPROM_SIZE));
    end else if (!wait_region_0_select_n) begin
      hit.vram = in_win(full_addr, `HDRC_VRAM_BASE,
                        `HDRC_VRAM_SIZE);
      hit.pal_lcd = in_win(full_addr, `HDRC_PAL_LCD_BASE,
                           `HDRC_WIN4K);
      hit.pal_crt = in_win(full_addr, `HDRC_PAL_CRT_BASE,
                           `HDRC_WIN4K);
      hit.blit = in_win(full_addr, `HDRC_BLIT_BASE, `HDRC_WIN4K);
      hit.usb = in_win(full_addr, `HDRC_USB_BASE, `HDRC_WIN4K);
      hit.flash = in_win(full_addr, `HDRC_FLASH_BASE, `HDRC_WIN4K);
      hit.debug = in_win(full_addr, `HDRC_DEBUG_BASE, `HDRC_WIN4K);
      hit.iobus = in_win(full_addr, `HDRC_IOBUS_BASE,
                         `HDRC_IOBUS_SIZE);
      hit.pc_io = in_win(full_addr, `HDRC_PCIO0_BASE, `HDRC_PCIO_SIZE) ||
                  in_win(full_addr, `HDRC_PCIO1_BASE,
                         `HDRC_PCIO_SIZE);
      hit.pc_mem = in_win(full_addr, `HDRC_PCMEM0_BASE,
                          `HDRC_PCMEM0_SIZE);
      need_wait = |hit;
    end else if (!wait_region_1_select_n) begin
      hit.pc_mem = in_win(full_addr, `HDRC_PCMEM1_BASE,
                          `HDRC_PCMEM1_SIZE);
      need_wait = hit.pc_mem;
    end else if (!register_region_select_n) begin
      hit.reg_bus = in_win(full_addr, `HDRC_RBUS_BASE, `HDRC_WIN4K);
      hit.reg_disp = in_win(full_addr, `HDRC_RDISP_BASE, `HDRC_WIN4K);
      hit.reg_pccard = in_win(full_addr, `HDRC_RPCC_BASE, `HDRC_WIN4K);
      hit.reg_iobus = in_win(full_addr, `HDRC_RIOB_BASE, `HDRC_WIN4K);
      hit.reg_power = in_win(full_addr, `HDRC_RPWR_BASE, `HDRC_WIN4K);
      hit.reg_intr = in_win(full_addr, `HDRC_RINT_BASE, `HDRC_WIN4K);
      ctrl_hit = (full_addr ==
                  `HDRC_RPWR_BASE + `HDRC_ROM_CTRL_OFS);
    end
  end

  // bank select pattern, active low
  always_comb begin
    bank_n = 8'hff;
    if (rom_hit) begin
      case (size_q)
        `HDRC_SZ_4MB: begin
          if (upper_q[`HDRC_A25]) begin
            bank_n[upper_q[`HDRC_A24:`HDRC_A22]] = 1'b0;
          end
        end
        `HDRC_SZ_16MB: begin
          bank_n[{1'b1, upper_q[`HDRC_A25:`HDRC_A24]}] = 1'b0;
          // bank 0 pin becomes address bit 23 of the larger parts
          bank_n[0] = upper_q[`HDRC_A23];
        end
        default: begin
          bank_n[upper_q[`HDRC_A25:`HDRC_A23]] = 1'b0;
        end
      endcase
    end
  end

  assign start = (state_q == hdrc_pkg::HDRC_IDLE) && any_cs && strobe;

  // upper address arrives multiplexed on the low pins during the strobe
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      upper_q <= 13'h0000;
    end else if (clk_en && upper_addr_latch_strobe) begin
      upper_q <= host_addr;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      size_q <= `HDRC_SZ_RST;
    end else if (clk_en && start && ctrl_hit && !host_wr_n &&
                 !host_byte_en_n[0]) begin
      size_q <= host_wdata[`HDRC_SZ_MSB:`HDRC_SZ_LSB];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= hdrc_pkg::HDRC_IDLE;
    end else if (clk_en) begin
      case (state_q)
        hdrc_pkg::HDRC_IDLE: begin
          if (start) begin
            state_q <= hdrc_pkg::HDRC_ACTIVE;
          end
        end
        hdrc_pkg::HDRC_ACTIVE: begin
          if (!strobe) begin
            state_q <= hdrc_pkg::HDRC_IDLE;
          end else if (!wait_q || unit_done) begin
            state_q <= hdrc_pkg::HDRC_HELD;
          end
        end
        hdrc_pkg::HDRC_HELD: begin
          if (!strobe) begin
            state_q <= hdrc_pkg::HDRC_IDLE;
          end
        end
        default: begin
          state_q <= hdrc_pkg::HDRC_IDLE;
        end
      endcase
    end
  end

  // access attributes held for the whole access, cleared when it ends
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_q <= '0;
      wait_q <= 1'b0;
      ctrl_q <= 1'b0;
      rom_q <= 1'b0;
      rd_q <= 1'b0;
      bank_q <= 8'hff;
    end else if (clk_en) begin
      if (start) begin
        sel_q <= hit;
        wait_q <= need_wait;
        ctrl_q <= ctrl_hit;
        // a reserved rom slot selects no bank, so it must not enable the rom
        rom_q <= rom_hit && (bank_n != 8'hff);
        rd_q <= !host_rd_n;
        bank_q <= bank_n;
      end else if (state_q != hdrc_pkg::HDRC_IDLE && !strobe) begin
        sel_q <= '0;
        wait_q <= 1'b0;
        ctrl_q <= 1'b0;
        rom_q <= 1'b0;
        rd_q <= 1'b0;
        bank_q <= 8'hff;
      end
    end
  end

  // rom enable lags the strobe by two cycles, covered by host rom waits
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rom_oe_n_q <= 1'b1;
    end else if (clk_en) begin
      rom_oe_n_q <= !(rom_q && rd_q && !host_rd_n);
    end
  end

  // the rom drives the host data bus itself, so rom reads are not driven
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 32'h00000000;
      rdata_oe_n_q <= 1'b1;
    end else if (clk_en) begin
      if (rd_q && !rom_q && !host_rd_n) begin
        rdata_oe_n_q <= 1'b0;
        if (ctrl_q) begin
          rdata_q <= {30'h00000000, size_q};
        end else if (|sel_q) begin
          rdata_q <= unit_rdata;
        end else begin
          rdata_q <= 32'h00000000;
        end
      end else begin
        rdata_oe_n_q <= 1'b1;
        rdata_q <= 32'h00000000;
      end
    end
  end

  // combinational so the host sees wait in the strobe's first cycle
  assign host_wait_out_n = !((start && need_wait) ||
                             (state_q == hdrc_pkg::HDRC_ACTIVE &&
                              wait_q && !unit_done));

  assign unit_sel = sel_q;
  assign rom_upper_addr = upper_q[`HDRC_A22:`HDRC_A13];
  assign rom_bank_select_pins = bank_q;
  assign rom_oe_n = rom_oe_n_q;
  assign rom_bank_size_sel = size_q;
  assign host_rdata = rdata_q;
  assign host_rdata_oe_n = rdata_oe_n_q;

endmodule
`default_nettype wire

// ---- tb/hdrc_top_props.sv ----
// checker on the host decoder ports
// assumes one clock domain, bound to every hdrc_top
`timescale 1ns/1ps
`default_nettype none
module hdrc_top_props (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [12:0] host_addr,
  input wire logic upper_addr_latch_strobe,
  input wire logic boot_region_select_n,
  input wire logic wait_region_0_select_n,
  input wire logic wait_region_1_select_n,
  input wire logic register_region_select_n,
  input wire logic unit_done,
  input wire logic host_wait_out_n,
  input wire hdrc_pkg::hdrc_unit_sel_s unit_sel,
  input wire logic [9:0] rom_upper_addr,
  input wire logic [7:0] rom_bank_select_pins,
  input wire logic rom_oe_n,
  input wire logic [1:0] rom_bank_size_sel
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_reg_no_wait: assert property (!register_region_select_n &&
    boot_region_select_n && wait_region_0_select_n &&
    wait_region_1_select_n |-> host_wait_out_n)
    else $error("wait in register region");
  a_boot_no_wait: assert property (!boot_region_select_n |->
    host_wait_out_n) else $error("wait in boot region");
  a_wait_cause: assert property (!host_wait_out_n |->
    !(wait_region_0_select_n && wait_region_1_select_n))
    else $error("wait outside wait regions");
  a_done_release: assert property (unit_done && |unit_sel[15:6] |->
    host_wait_out_n) else $error("wait kept after unit done");
  a_oe_after_bank: assert property ($fell(rom_oe_n) |->
    $past(rom_bank_select_pins) != 8'hff) else $error("rom oe without bank");
  a_bank_from_boot: assert property (rom_bank_select_pins != 8'hff |->
    !$past(boot_region_select_n)) else $error("bank outside boot region");
  a_big_bank_pins: assert property (rom_bank_size_sel == 2'h2 |->
    rom_bank_select_pins[3:1] == 3'h7) else $error("unused banks driven");
  a_upper_latch: assert property (upper_addr_latch_strobe && clk_en
    ##1 clk_en [*2] |-> rom_upper_addr == $past(host_addr[9:0], 2))
    else $error("rom upper address not latched");
  a_one_unit: assert property ($onehot0(unit_sel))
    else $error("two units selected");
  cover property ($fell(rom_oe_n));
  cover property ($fell(host_wait_out_n));
  cover property (rom_bank_size_sel == 2'h2 && !rom_oe_n);
endmodule

bind hdrc_top hdrc_top_props u_props (.ref_clk, .reset_n, .clk_en,
  .host_addr, .upper_addr_latch_strobe, .boot_region_select_n,
  .wait_region_0_select_n, .wait_region_1_select_n,
  .register_region_select_n, .unit_done, .host_wait_out_n, .unit_sel,
  .rom_upper_addr, .rom_bank_select_pins, .rom_oe_n, .rom_bank_size_sel);
`default_nettype wire

// ---- tb/hdrc_unit_model.sv ----
// internal unit stand-in: answers selects after a set delay
// assumes selects come registered from the decoder
`timescale 1ns/1ps
`default_nettype none
module hdrc_unit_model (
  input wire logic clk,
  input wire hdrc_pkg::hdrc_unit_sel_s sel,
  input wire logic [3:0] dly,
  input wire logic [31:0] data,
  output logic done,
  output logic [31:0] rdata
);
  logic [3:0] cnt = 4'h0;
  logic [31:0] junk = 32'h5a5a5a5a;
  initial done = 1'b0;
  always @(posedge clk) begin
    junk <= ~junk;
    if (|sel[15:6]) begin
      if (cnt != dly) cnt <= cnt + 4'h1;
      done <= cnt == dly;
    end else begin
      cnt <= 4'h0;
      done <= 1'b0;
    end
  end
  // unselected bus toggles so a stale value can never pass as data
  assign rdata = |sel ? data : junk;
endmodule
`default_nettype wire

// ---- tb/hdrc_top_tb_top.sv ----
// self-checking bench for the host decoder
// assumes the decoder, its package and the unit model compiled first
`timescale 1ns/1ps
`default_nettype none
module hdrc_top_tb_top;
  logic ref_clk = 0, reset_n = 0, clk_en = 1, eprom_debug_mode = 0;
  logic upper_addr_latch_strobe = 0, host_rd_n = 1, host_wr_n = 1;
  logic boot_region_select_n = 1, wait_region_0_select_n = 1;
  logic wait_region_1_select_n = 1, register_region_select_n = 1;
  logic [12:0] host_addr = 13'h0;
  logic [3:0] host_byte_en_n = 4'h0, dly = 4'h0;
  logic [31:0] host_wdata = 32'h0, ud = 32'h0, unit_rdata, host_rdata, a, r;
  logic unit_done, host_wait_out_n, rdata_oe_n, rom_oe_n;
  hdrc_pkg::hdrc_unit_sel_s unit_sel;
  logic [9:0] rom_upper_addr;
  logic [7:0] rom_bank_select_pins;
  logic [1:0] rom_bank_size_sel, sz = 2'h0;
  int errors = 0, comparisons = 0, cyc = 0, seed = 61428;
  logic [31:0] tbl[26] = '{32'h6c000000, 32'h6c3ffffc, 32'h6c400000,
    32'h6c401000, 32'h6c402000, 32'h6c403000, 32'h6c410000, 32'h6c415ffc,
    32'h6c416000, 32'h6c418000, 32'h6c419000, 32'h6c41a000, 32'h6c404000,
    32'h6c600000, 32'h6c700000, 32'h6c800000, 32'h70000000, 32'h73fffffc,
    32'h10800000, 32'h10801000, 32'h10805000, 32'h10806000, 32'h10807000,
    32'h10808000, 32'h10809000, 32'h10804000};

  hdrc_top dut (.ref_clk, .reset_n, .clk_en, .host_addr,
    .upper_addr_latch_strobe, .host_rd_n, .host_wr_n, .host_byte_en_n,
    .host_wdata, .boot_region_select_n, .wait_region_0_select_n,
    .wait_region_1_select_n, .register_region_select_n, .eprom_debug_mode,
    .unit_rdata, .unit_done, .host_rdata, .host_rdata_oe_n(rdata_oe_n),
    .host_wait_out_n, .unit_sel, .rom_upper_addr, .rom_bank_select_pins,
    .rom_oe_n, .rom_bank_size_sel);
  hdrc_unit_model u_unit (.clk(ref_clk), .sel(unit_sel), .dly, .data(ud),
    .done(unit_done), .rdata(unit_rdata));

  initial forever #50 ref_clk = ~ref_clk;

  task automatic stop_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic hdrc_pkg::hdrc_unit_sel_s exp_sel(input logic [31:0] a);
    hdrc_pkg::hdrc_unit_sel_s s;
    s = '0;
    s.vram = a[31:22] == 10'h1b0;
    s.pal_lcd = a[31:12] == 20'h6c400;
    s.pal_crt = a[31:12] == 20'h6c401;
    s.blit = a[31:12] == 20'h6c402;
    s.usb = a[31:12] == 20'h6c403;
    s.flash = a[31:12] == 20'h6c418;
    s.debug = a[31:12] == 20'h6c419;
    s.iobus = a[31:12] >= 20'h6c410 && a[31:12] < 20'h6c416;
    s.pc_io = a[31:21] == 11'h363;
    s.pc_mem = a[31:23] >= 9'h0d9 && a[31:23] < 9'h0e8;
    s.reg_bus = a[31:12] == 20'h10800;
    s.reg_disp = a[31:12] == 20'h10801;
    s.reg_pccard = a[31:12] == 20'h10805;
    s.reg_iobus = a[31:12] == 20'h10806;
    s.reg_power = a[31:12] == 20'h10807;
    s.reg_intr = a[31:12] == 20'h10808;
    return s;
  endfunction

  function automatic logic [7:0] exp_pins(input logic [31:0] a);
    logic [7:0] p;
    p = 8'hff;
    if (eprom_debug_mode && a[31:21] != 11'h0fe) return p;
    case (sz)
      2'h1: if (a[25]) p[a[24:22]] = 1'b0;
      2'h2: begin
        p[{1'b1, a[25:24]}] = 1'b0;
        p[0] = a[23];
      end
      default: p[a[25:23]] = 1'b0;
    endcase
    return p;
  endfunction

  task automatic acc(input logic [31:0] a, input logic w,
                     input logic [3:0] be, input logic [31:0] d);
    hdrc_pkg::hdrc_unit_sel_s es;
    logic sw;
    int n;
    logic [7:0] ep;
    es = exp_sel(a);
    ep = a[31:26] == 6'h07 ? exp_pins(a) : 8'hff;
    sw = 1'b0;
    n = 0;
    @(posedge ref_clk);
    host_addr <= a[25:13];
    upper_addr_latch_strobe <= 1'b1;
    @(posedge ref_clk);
    upper_addr_latch_strobe <= 1'b0;
    repeat (2) @(posedge ref_clk);
    host_addr <= a[12:0];
    host_wdata <= d;
    host_byte_en_n <= be;
    ud <= $random(seed);
    dly <= 4'($random(seed));
    boot_region_select_n <= a[31:26] != 6'h07;
    wait_region_0_select_n <= a[31:26] != 6'h1b;
    wait_region_1_select_n <= a[31:26] != 6'h1c;
    register_region_select_n <= a[31:26] != 6'h04;
    host_wr_n <= !w;
    host_rd_n <= w;
    if (w && a == 32'h10807008 && !be[0]) sz = d[1:0];
    do begin
      @(posedge ref_clk);
      #1 sw |= !host_wait_out_n;
      n++;
    end while (n < 40 && (n < 3 || host_wait_out_n !== 1'b1));
    chk(n < 40, 1'b1);
    chk(unit_sel, es);
    chk(sw, |es[15:6]);
    chk(rom_bank_select_pins, ep);
    chk(rom_oe_n, w || ep == 8'hff);
    chk(rdata_oe_n, w || ep != 8'hff);
    chk(rom_upper_addr, a[22:13]);
    if (!w && ep == 8'hff)
      chk(host_rdata,
          a == 32'h10807008 ? {30'h0, sz} : |es ? ud : 32'h0);
    @(posedge ref_clk);
    {boot_region_select_n, wait_region_0_select_n, wait_region_1_select_n,
     register_region_select_n, host_rd_n, host_wr_n} <= 6'h3f;
    repeat (2) @(posedge ref_clk);
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    #1 chk(rom_bank_size_sel, 2'h0);
    chk(host_wait_out_n, 1'b1);
    foreach (tbl[i]) acc(tbl[i], 1'b0, 4'h0, 32'h0);
    acc(32'h10807008, 1'b1, 4'h1, 32'h2);
    chk(rom_bank_size_sel, sz);
    for (int m = 1; m < 5; m++) begin
      acc(32'h10807008, 1'b1, 4'h0, 32'(m & 3));
      acc(32'h10807008, 1'b0, 4'h0, 32'h0);
      chk(rom_bank_size_sel, sz);
      for (int k = 0; k < 16; k++) acc(32'h1c000000 + k * 32'h400000,
        1'b0, 4'h0, 32'h0);
    end
    @(posedge ref_clk);
    eprom_debug_mode <= 1'b1;
    acc(32'h1fc00000, 1'b0, 4'h0, 32'h0);
    acc(32'h1fe00000, 1'b0, 4'h0, 32'h0);
    @(posedge ref_clk);
    eprom_debug_mode <= 1'b0;
    // frozen edges must not load the upper latch
    clk_en <= 1'b0;
    host_addr <= 13'h1555;
    upper_addr_latch_strobe <= 1'b1;
    repeat (3) @(posedge ref_clk);
    clk_en <= 1'b1;
    #1 chk(rom_upper_addr, 32'h300);
    @(posedge ref_clk);
    upper_addr_latch_strobe <= 1'b0;
    #1 chk(rom_upper_addr, 32'h155);
    repeat (40) begin
      r = $random(seed);
      case (r[1:0])
        2'h0: a = {6'h07, r[27:4], 2'h0};
        2'h1: a = {6'h1b, r[27:4], 2'h0};
        2'h2: a = {6'h1c, r[27:4], 2'h0};
        default: a = {16'h1080, r[17:4], 2'h0};
      endcase
      acc(a, r[2] && r[1:0] != 2'h0, r[31:28], $random(seed));
    end
    stop_test();
  end
endmodule
`default_nettype wire
